//--- hdl/adc_serial_port_pkg.sv
package adc_serial_port_pkg;
   localparam int RESULT_W = 16;
   localparam logic [4:0] RESULT_BITS = 5'h10;
   localparam int FIFO_DEPTH = 16;
   localparam int QUARTER_CYCLES = 4;
   localparam int REG_ADDR_W = 4;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam logic CTRL_RESET_VAL = 1'b1;
   localparam int ST_FRAME_BIT = 0;
   localparam int ST_SERIAL_BIT = 1;
   localparam int ST_EMPTY_BIT = 2;
   localparam int ST_EXTCLK_BIT = 3;
   localparam int PAR_BIT6 = 6;
   localparam int PAR_BIT7 = 7;
   localparam int PAR_BIT8 = 8;
   // synchroniser lane positions
   localparam int SY_MODE = 0;
   localparam int SY_CLKSRC = 1;
   localparam int SY_CODING = 2;
   localparam int SY_POL = 3;
   localparam int SY_INV = 4;
   localparam int SY_RDC = 5;
   localparam int SY_SCLK = 6;
   localparam int SY_N = 7;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SHIFT = 2'b01,
      ST_CHAIN = 2'b10
   } port_state_t;
endpackage

//--- hdl/adc_serial_output_port.sv
// How it works
// - in serial mode, polarity select low gives active-high frame sync, high gives active-low.
// - clock invert flips serial clock use in both internal and external clock modes.
// - external clock: chain-in level appears on serial out after 16 clock periods.
// - internal clock, read-mode high: result shifts out even while conversion runs.
// - internal clock, read-mode low: serial output starts only after conversion completes.
// - result held in a shift register and sent most significant bit first.
// - output word coding follows the output coding select level.
// - internal clock: each output bit is stable across both serial clock edges.
// - external clock, no invert: bits change on rising edge, host samples falling.
// - external clock, invert: bits change on falling edge, host samples rising.
// - parallel mode: shared pins drive result bits 6, 7, 8; serial out drives bit 8.
// - in serial mode, clock source low drives internal clock out; high takes host clock as input.
// - coding select high is straight binary, low inverts the msb (twos complement).
// - internal clock frame sync asserts at start and holds while data is valid.
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module result_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [WIDTH-1:0] i_wr_data,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   output logic [WIDTH-1:0] o_rd_data,
   output logic o_rd_valid,
   input wire logic i_rd_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic push, pop;

   always_comb begin
      push = i_wr_valid && (cnt_reg != (AW+1)'(DEPTH));
      pop = i_rd_ready && (cnt_reg != '0);
      wp_next = push ? AW'(wp_reg + 1'b1) : wp_reg;
      rp_next = pop ? AW'(rp_reg + 1'b1) : rp_reg;
      cnt_next = cnt_reg;
      if (push && !pop) begin
         cnt_next = (AW+1)'(cnt_reg + 1'b1);
      end else if (pop && !push) begin
         cnt_next = (AW+1)'(cnt_reg - 1'b1);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wp_reg <= wp_next;
         rp_reg <= rp_next;
         cnt_reg <= cnt_next;
      end
   end

   // storage has no reset so it maps onto plain ram
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wp_reg] <= i_wr_data;
      end
   end

   assign o_wr_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign o_rd_valid = (cnt_reg != '0);
   assign o_rd_data = mem[rp_reg];
endmodule // result_fifo

module adc_serial_output_port
   import adc_serial_port_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH,
   parameter int QUARTER = QUARTER_CYCLES
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // register port
   input wire logic [REG_ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // converter side
   input wire logic [RESULT_W-1:0] i_result_data,
   input wire logic i_result_valid,
   output logic o_result_ready,
   input wire logic i_conv_busy,
   input wire logic i_read_req,
   // strap pins
   input wire logic i_port_mode_sel,
   input wire logic i_clock_source_sel,
   input wire logic i_output_coding_sel,
   // shared pins
   input wire logic i_frame_sync_polarity_sel,
   output logic o_result_bit6,
   output logic o_result_bit6_oe,
   input wire logic i_serial_clock_invert,
   output logic o_result_bit7,
   output logic o_result_bit7_oe,
   input wire logic i_read_mode_or_chain_in,
   output logic o_result_bit8,
   output logic o_result_bit8_oe,
   // serial link
   input wire logic i_serial_clock,
   output logic o_serial_clock,
   output logic o_serial_clock_oe,
   output logic o_serial_result_out,
   output logic o_frame_sync
);
   localparam int DW = $clog2(QUARTER) + 1;

   // straight binary when select high, else msb flipped
   function automatic logic [RESULT_W-1:0] code_word(input logic [RESULT_W-1:0] w,
                                                     input logic straight);
      code_word = {w[RESULT_W-1] ^ ~straight, w[RESULT_W-2:0]};
   endfunction

   logic [SY_N-1:0] raw, sy1_reg, sy2_reg;
   assign raw = {i_serial_clock, i_read_mode_or_chain_in, i_serial_clock_invert,
                 i_frame_sync_polarity_sel, i_output_coding_sel, i_clock_source_sel,
                 i_port_mode_sel};
   genvar g;
   generate
      for (g = 0; g < SY_N; g++) begin : g_sync
         always_ff @(posedge i_clk) begin
            if (i_srst) begin
               sy1_reg[g] <= 1'b0;
               sy2_reg[g] <= 1'b0;
            end else begin
               sy1_reg[g] <= raw[g];
               sy2_reg[g] <= sy1_reg[g];
            end
         end
      end
   endgenerate

   logic serial, extclk, straight, pol, inv, rdc;
   assign serial = sy2_reg[SY_MODE];
   assign extclk = sy2_reg[SY_CLKSRC];
   assign straight = sy2_reg[SY_CODING];
   assign pol = sy2_reg[SY_POL];
   assign inv = sy2_reg[SY_INV];
   assign rdc = sy2_reg[SY_RDC];

   logic [RESULT_W-1:0] fifo_data;
   logic fifo_valid, fifo_pop;
   result_fifo #(.WIDTH(RESULT_W), .DEPTH(DEPTH)) u_fifo (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_wr_data(i_result_data),
      .i_wr_valid(i_result_valid),
      .o_wr_ready(o_result_ready),
      .o_rd_data(fifo_data),
      .o_rd_valid(fifo_valid),
      .i_rd_ready(fifo_pop)
   );

   port_state_t st_reg, st_next;
   logic [RESULT_W-1:0] sr_reg, sr_next, par_reg, par_next;
   logic [4:0] bits_reg, bits_next;
   logic [1:0] ph_reg, ph_next;
   logic [DW-1:0] div_reg, div_next;
   logic sclk_prev_reg, sclk_prev_next;
   logic sdo_reg, sdo_next, fs_reg, fs_next, sck_reg, sck_next;
   logic b6_reg, b6_next, b7_reg, b7_next, b8_reg, b8_next;
   logic oe_reg, oe_next, sck_oe_reg, sck_oe_next;
   logic en_reg, en_next;
   logic [31:0] rdata_reg, rdata_next;
   logic tick, upd_edge, start_ok, frame;

   always_comb begin
      st_next = st_reg;
      sr_next = sr_reg;
      par_next = par_reg;
      bits_next = bits_reg;
      ph_next = ph_reg;
      div_next = div_reg;
      sclk_prev_next = sy2_reg[SY_SCLK];
      fifo_pop = 1'b0;
      tick = (div_reg == DW'(QUARTER - 1));
      div_next = tick ? '0 : DW'(div_reg + 1'b1);
      // host clock edge that moves the data, chosen by invert
      upd_edge = inv ? (sclk_prev_reg && !sy2_reg[SY_SCLK])
                     : (!sclk_prev_reg && sy2_reg[SY_SCLK]);
      // read-mode pin gates start only with internal clock
      start_ok = extclk || rdc || !i_conv_busy;
      en_next = en_reg;
      if (i_wr && i_addr == REG_CTRL) begin
         en_next = i_wdata[CTRL_ENABLE_BIT];
      end
      case (st_reg)
         ST_IDLE: begin
            ph_next = 2'b00;
            div_next = '0;
            if (!serial) begin
               if (fifo_valid) begin
                  par_next = code_word(fifo_data, straight);
                  fifo_pop = 1'b1;
               end
            end else if (en_reg && i_read_req && fifo_valid && start_ok) begin
               sr_next = code_word(fifo_data, straight);
               par_next = sr_next;
               fifo_pop = 1'b1;
               bits_next = 5'h00;
               st_next = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (extclk) begin
               if (!i_read_req) begin
                  st_next = ST_IDLE;
               end else if (upd_edge) begin
                  sr_next = {sr_reg[RESULT_W-2:0], rdc};
                  bits_next = 5'(bits_reg + 1'b1);
                  if (bits_next == RESULT_BITS) begin
                     st_next = ST_CHAIN;
                  end
               end
            end else if (tick) begin
               ph_next = 2'(ph_reg + 1'b1);
               // shift mid low phase so the bit spans both edges
               if (ph_reg == 2'b11) begin
                  sr_next = {sr_reg[RESULT_W-2:0], 1'b0};
                  bits_next = 5'(bits_reg + 1'b1);
                  if (bits_next == RESULT_BITS) begin
                     st_next = ST_IDLE;
                  end
               end
            end
         end
         ST_CHAIN: begin
            if (!i_read_req || !extclk) begin
               st_next = ST_IDLE;
            end else if (upd_edge) begin
               sr_next = {sr_reg[RESULT_W-2:0], rdc};
            end
         end
         default: begin
            st_next = ST_IDLE;
         end
      endcase
      if (!serial && st_reg != ST_IDLE) begin
         st_next = ST_IDLE;
      end
      frame = (st_next != ST_IDLE);
      // outputs
      sck_oe_next = serial && !extclk;
      sck_next = ((ph_next == 2'b01) || (ph_next == 2'b10)) && frame && !extclk;
      sck_next = sck_next ^ inv;
      fs_next = (serial && !extclk && frame) ^ pol;
      oe_next = !serial;
      b6_next = par_next[PAR_BIT6];
      b7_next = par_next[PAR_BIT7];
      b8_next = par_next[PAR_BIT8];
      sdo_next = serial ? (frame && sr_next[RESULT_W-1]) : par_next[PAR_BIT8];
      rdata_next = 32'h0000_0000;
      if (i_rd && i_addr == REG_CTRL) begin
         rdata_next[CTRL_ENABLE_BIT] = en_reg;
      end else if (i_rd && i_addr == REG_STATUS) begin
         rdata_next[ST_FRAME_BIT] = (st_reg != ST_IDLE);
         rdata_next[ST_SERIAL_BIT] = serial;
         rdata_next[ST_EMPTY_BIT] = !fifo_valid;
         rdata_next[ST_EXTCLK_BIT] = extclk;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_reg <= ST_IDLE;
         sr_reg <= '0;
         par_reg <= '0;
         bits_reg <= 5'h00;
         ph_reg <= 2'b00;
         div_reg <= '0;
         sclk_prev_reg <= 1'b0;
         sdo_reg <= 1'b0;
         fs_reg <= 1'b0;
         sck_reg <= 1'b0;
         sck_oe_reg <= 1'b0;
         oe_reg <= 1'b0;
         b6_reg <= 1'b0;
         b7_reg <= 1'b0;
         b8_reg <= 1'b0;
         en_reg <= CTRL_RESET_VAL;
         rdata_reg <= 32'h0000_0000;
      end else begin
         st_reg <= st_next;
         sr_reg <= sr_next;
         par_reg <= par_next;
         bits_reg <= bits_next;
         ph_reg <= ph_next;
         div_reg <= div_next;
         sclk_prev_reg <= sclk_prev_next;
         sdo_reg <= sdo_next;
         fs_reg <= fs_next;
         sck_reg <= sck_next;
         sck_oe_reg <= sck_oe_next;
         oe_reg <= oe_next;
         b6_reg <= b6_next;
         b7_reg <= b7_next;
         b8_reg <= b8_next;
         en_reg <= en_next;
         rdata_reg <= rdata_next;
      end
   end

   assign o_rdata = rdata_reg;
   assign o_serial_result_out = sdo_reg;
   assign o_frame_sync = fs_reg;
   assign o_serial_clock = sck_reg;
   assign o_serial_clock_oe = sck_oe_reg;
   assign o_result_bit6 = b6_reg;
   assign o_result_bit7 = b7_reg;
   assign o_result_bit8 = b8_reg;
   assign o_result_bit6_oe = oe_reg;
   assign o_result_bit7_oe = oe_reg;
   assign o_result_bit8_oe = oe_reg;
endmodule // adc_serial_output_port

`default_nettype wire

//--- sim/adc_serial_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module adc_serial_port_chk #(
   parameter int QUARTER = 4
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // watched pins
   input wire logic i_conv_busy,
   input wire logic i_frame_sync_polarity_sel,
   input wire logic i_serial_clock_invert,
   input wire logic i_read_mode_or_chain_in,
   input wire logic o_result_bit6_oe,
   input wire logic o_result_bit7_oe,
   input wire logic o_result_bit8,
   input wire logic o_result_bit8_oe,
   input wire logic o_serial_clock,
   input wire logic o_serial_clock_oe,
   input wire logic o_serial_result_out,
   input wire logic o_frame_sync
);
   logic act, sclk_reg, sclk_next;
   logic [9:0] len_reg, len_next;
   logic [5:0] edge_reg, edge_next;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);
   // a polarity change makes short false frames, so length checks skip them
   assign act = o_serial_clock_oe && (o_frame_sync != i_frame_sync_polarity_sel);
   always_comb begin
      sclk_next = o_serial_clock;
      len_next = act ? len_reg + 10'h001 : 10'h000;
      edge_next = act ? edge_reg + {5'h00, o_serial_clock != sclk_reg} : 6'h00;
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         sclk_reg <= 1'b0;
         len_reg <= 10'h000;
         edge_reg <= 6'h00;
      end else begin
         sclk_reg <= sclk_next;
         len_reg <= len_next;
         edge_reg <= edge_next;
      end
   end
   a_pins_together: assert property (
      o_result_bit6_oe |-> o_result_bit7_oe && o_result_bit8_oe) else $error("pins split");
   a_clock_owner: assert property (
      o_serial_clock_oe |-> !o_result_bit6_oe && !o_result_bit8_oe) else $error("both driven");
   a_par_serial_bit: assert property (
      o_result_bit8_oe |-> o_serial_result_out == o_result_bit8) else $error("not bit 8");
   a_bit_steady: assert property (
      o_serial_clock_oe && $past(o_serial_clock_oe) && $changed(o_serial_clock)
      |-> $stable(o_serial_result_out) ##1 $stable(o_serial_result_out)) else $error("data moved");
   a_frame_length: assert property (
      $fell(act) && len_reg > 10'h008 |-> len_reg == 64 * QUARTER) else $error("sync length");
   a_frame_clocks: assert property (
      $fell(act) && len_reg > 10'h008 |-> edge_reg == 6'h20) else $error("clock count");
   a_busy_gate: assert property (
      $rose(act) && !i_read_mode_or_chain_in |-> !$past(i_conv_busy)) else $error("early read");
   a_clock_idle: assert property (
      (o_serial_clock_oe && !act && $stable(i_serial_clock_invert))[*6]
      |-> o_serial_clock == i_serial_clock_invert) else $error("idle clock level");
endmodule // adc_serial_port_chk
bind adc_serial_output_port adc_serial_port_chk #(.QUARTER(QUARTER)) chk_i (.i_clk, .i_srst,
   .i_conv_busy, .i_frame_sync_polarity_sel, .i_serial_clock_invert, .i_read_mode_or_chain_in,
   .o_result_bit6_oe, .o_result_bit7_oe, .o_result_bit8, .o_result_bit8_oe, .o_serial_clock,
   .o_serial_clock_oe, .o_serial_result_out, .o_frame_sync);
`default_nettype wire

//--- sim/serial_host.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host (
   // bench control
   input wire logic i_run,
   input wire logic i_ext,
   input wire logic i_inv,
   input wire logic i_clear,
   // serial link
   input wire logic i_dev_sclk,
   input wire logic i_sdo,
   output logic o_sclk,
   output logic [23:0] o_shift,
   output logic [5:0] o_cnt
);
   logic eff, samp;
   assign eff = i_ext ? o_sclk : i_dev_sclk;
   // sample opposite the update edge
   assign samp = i_ext ? i_inv : ~i_inv;
   // idle at the sampling-off level so the first edge samples the msb
   always begin
      o_sclk = ~i_inv;
      @(i_inv or i_run);
      if (i_run) begin
         repeat (36) begin
            #80;
            o_sclk = ~o_sclk;
         end
         wait (!i_run);
      end
   end
   always @(posedge i_clear or eff) begin
      if (i_clear) begin
         o_shift = 24'h000000;
         o_cnt = 6'h00;
      end else if (eff === samp) begin
         o_shift = {o_shift[22:0], i_sdo};
         o_cnt = o_cnt + 6'h01;
      end
   end
endmodule // serial_host
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import adc_serial_port_pkg::*;
   localparam int Q = 2;
   logic i_clk, i_srst, i_wr, i_rd, i_result_valid, i_conv_busy, i_read_req;
   logic mode, src, coding, pol, inv, rdc, run, clr, sclk_in, sclk, sclk_oe, sdo, fs, rdy;
   logic b6, b6_oe, b7, b7_oe, b8, b8_oe;
   logic [3:0] i_addr;
   logic [31:0] i_wdata, o_rdata, d;
   logic [15:0] i_result_data;
   logic [23:0] cap;
   logic [5:0] ncap;
   int error_cnt = 0;
   int n_compared = 0;
   adc_serial_output_port #(.QUARTER(Q)) uut (.i_clk, .i_srst, .i_addr, .i_wdata, .i_wr,
      .i_rd, .o_rdata, .i_result_data, .i_result_valid, .o_result_ready(rdy), .i_conv_busy,
      .i_read_req, .i_port_mode_sel(mode), .i_clock_source_sel(src),
      .i_output_coding_sel(coding), .i_frame_sync_polarity_sel(b6_oe ? b6 : pol),
      .o_result_bit6(b6), .o_result_bit6_oe(b6_oe), .i_serial_clock_invert(b7_oe ? b7 : inv),
      .o_result_bit7(b7), .o_result_bit7_oe(b7_oe), .i_read_mode_or_chain_in(b8_oe ? b8 : rdc),
      .o_result_bit8(b8), .o_result_bit8_oe(b8_oe), .i_serial_clock(sclk_in),
      .o_serial_clock(sclk), .o_serial_clock_oe(sclk_oe), .o_serial_result_out(sdo),
      .o_frame_sync(fs));
   serial_host host (.i_run(run), .i_ext(src), .i_inv(inv), .i_clear(clr), .i_dev_sclk(sclk),
      .i_sdo(sdo), .o_sclk(sclk_in), .o_shift(cap), .o_cnt(ncap));
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic reg_op(input logic wr, input logic [3:0] a, input logic [31:0] v);
      @(posedge i_clk);
      {i_wr, i_rd, i_addr, i_wdata} <= {wr, !wr, a, v};
      @(posedge i_clk);
      {i_wr, i_rd} <= 2'b00;
      #1 d = o_rdata;
   endtask
   task automatic push(input logic [15:0] w);
      @(posedge i_clk);
      {i_result_valid, i_result_data} <= {1'b1, w};
      @(posedge i_clk);
      i_result_valid <= 1'b0;
   endtask
   function automatic logic [15:0] code(input logic [15:0] w, input logic c);
      return c ? w : {~w[15], w[14:0]};
   endfunction
   // straps pass a synchroniser, so settle before clearing the host capture
   task automatic straps(input logic [5:0] s);
      @(posedge i_clk);
      {mode, src, coding, pol, inv, rdc} <= s;
      tick(6);
      clr <= 1'b1;
      tick(1);
      clr <= 1'b0;
   endtask
   task automatic t_regs;
      reg_op(1'b0, REG_CTRL, 32'h0);
      chk(d, 32'h1);
      reg_op(1'b0, REG_STATUS, 32'h0);
      chk(d, 32'h6);
      reg_op(1'b0, 4'h8, 32'h0);
      chk(d, 32'h0);
      reg_op(1'b1, REG_CTRL, 32'h0);
      push(16'h1234);
      i_read_req <= 1'b1;
      tick(20);
      chk(fs, 1'b0);
      reg_op(1'b1, REG_CTRL, 32'h1);
      tick(64 * Q + 20);
      i_read_req <= 1'b0;
      chk(cap[15:0], 16'h1234);
   endtask
   task automatic t_int(input logic [5:0] s, input logic [15:0] w);
      int n;
      straps(s);
      n = 0;
      chk(fs, s[2]);
      {i_conv_busy, i_read_req} <= 2'b11;
      push(w);
      while (fs === s[2] && n < 40) begin
         tick(1);
         n++;
      end
      chk(fs, s[0] ? !s[2] : s[2]);
      i_conv_busy <= 1'b0;
      tick(64 * Q + 20);
      i_read_req <= 1'b0;
      chk({ncap, cap[15:0]}, {6'h10, code(w, s[3])});
      chk(fs, s[2]);
   endtask
   task automatic t_ext(input logic v, input logic [15:0] w);
      straps({4'b1100, v, 1'b1});
      chk({sclk_oe, fs}, 2'b00);
      i_read_req <= 1'b1;
      push(w);
      tick(4);
      run <= 1'b1;
      tick(760);
      {run, i_read_req} <= 2'b00;
      chk(cap[17:0], {code(w, 1'b0), 2'b11});
   endtask
   task automatic t_fifo;
      straps(6'b101001);
      for (int k = 0; k < FIFO_DEPTH; k++) push(16'h0100 + 16'(k) * 16'h0040);
      tick(1);
      chk(rdy, 1'b0);
      reg_op(1'b0, REG_STATUS, 32'h0);
      chk(d[ST_EMPTY_BIT], 1'b0);
      straps(6'b001001);
      tick(FIFO_DEPTH + 4);
      reg_op(1'b0, REG_STATUS, 32'h0);
      chk({rdy, d[ST_EMPTY_BIT]}, 2'b11);
      chk({b8_oe, b7_oe, b6_oe, sclk_oe, b8, b7, b6, sdo}, 8'he6);
   endtask
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      {i_srst, i_wr, i_rd, i_result_valid, i_conv_busy, i_read_req, run, clr} = 8'h80;
      {mode, src, coding, pol, inv, rdc} = 6'b101001;
      {i_addr, i_wdata, i_result_data} = '0;
      tick(5);
      i_srst <= 1'b0;
      straps(6'b101001);
      t_regs;
      t_int(6'b101001, 16'hb2c5);
      t_int(6'b100110, 16'h4e39);
      t_ext(1'b0, 16'hc3a5);
      t_ext(1'b1, 16'h5a3c);
      t_fifo;
      results;
   end
   initial begin
      #60000;
      error_cnt++;
      results;
   end
endmodule // tb_top
`default_nettype wire
